/* File: design/exec_pkg.sv */
// Package with operation codes and widths for the return/OR/rotate executor
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PC_W   = 13;
	localparam int MSB    = 7;

	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_OR_IMM    = 3'b001,
		OP_OR_MEM    = 3'b010,
		OP_SUB_RETURN = 3'b011,
		OP_RETURN_IMM = 3'b100,
		OP_IRQ_RETURN = 3'b101,
		OP_ROT_LEFT  = 3'b110
	} op_type;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} state_type;

	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ACCUM_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
endpackage

/* File: design/or_return_rotate_exec.sv */
// Executor for OR, return and rotate-left instructions of an 8-bit core
//
// How it works
// - OR immediate ORs the accumulator with the operand and updates only zero.
// - OR to memory writes accumulator OR byte back to memory, zero updated.
// - Plain return pops the stack into the program counter, flags untouched.
// - Return with immediate pops the counter and sets accumulator to operand.
// - Return from interrupt pops the counter and sets master irq enable.
// - A pending interrupt on that return is serviced before main code resumes.
// - Rotate left moves bit 7 into bit 0, writes memory back, flags untouched.
`timescale 1ns/1ps

module or_return_rotate_exec
	import exec_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              op_valid,
	input  wire op_type            op_code,
	input  wire logic [DATA_W-1:0] op_imm,
	input  wire logic [ADDR_W-1:0] op_addr,
	input  wire logic [PC_W-1:0]   stack_top,
	input  wire logic              irq_pending,
	input  wire logic [DATA_W-1:0] mem_rdata,
	output logic                   op_ready,
	output logic                   op_done,
	output logic [DATA_W-1:0]      accumulator_reg,
	output logic                   zero_flag,
	output logic                   master_irq_enable,
	output logic [PC_W-1:0]        pc_load_value,
	output logic                   pc_load,
	output logic                   stack_pop,
	output logic                   irq_take,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic                   mem_rd,
	output logic                   mem_wr,
	output logic [DATA_W-1:0]      mem_wdata
);

	// ==========================================================
	// State
	state_type         state, next_state;
	op_type            held_op, next_held_op;
	logic [DATA_W-1:0] next_accumulator_reg;
	logic              next_zero_flag;
	logic              next_master_irq_enable;
	logic [PC_W-1:0]   next_pc_load_value;
	logic              next_pc_load;
	logic              next_stack_pop;
	logic              next_irq_take;
	logic [ADDR_W-1:0] next_mem_addr;
	logic              next_mem_rd;
	logic              next_mem_wr;
	logic [DATA_W-1:0] next_mem_wdata;
	logic              next_op_done;
	logic              next_op_ready;
	logic [DATA_W-1:0] or_imm_res;
	logic [DATA_W-1:0] or_mem_res;
	logic [DATA_W-1:0] rot_res;

	assign or_imm_res = accumulator_reg | op_imm;
	assign or_mem_res = accumulator_reg | mem_rdata;
	assign rot_res = {mem_rdata[MSB-1:0], mem_rdata[MSB]};

	// ==========================================================
	// Next-value logic
	always_comb begin
		next_state             = state;
		next_held_op           = held_op;
		next_accumulator_reg   = accumulator_reg;
		next_zero_flag         = zero_flag;
		next_master_irq_enable = master_irq_enable;
		next_pc_load_value     = pc_load_value;
		next_pc_load           = 1'b0;
		next_stack_pop         = 1'b0;
		next_irq_take          = 1'b0;
		next_mem_addr          = mem_addr;
		next_mem_rd            = 1'b0;
		next_mem_wr            = 1'b0;
		next_mem_wdata         = mem_wdata;
		next_op_done           = 1'b0;
		next_op_ready          = op_ready;
		unique case (state)
			ST_IDLE: begin
				if (op_valid && op_ready) begin
					unique case (op_code)
						OP_OR_IMM: begin
							next_accumulator_reg = or_imm_res;
							next_zero_flag = (or_imm_res == ZERO_BYTE);
							next_op_done = 1'b1;
						end
						OP_SUB_RETURN, OP_RETURN_IMM, OP_IRQ_RETURN: begin
							next_pc_load_value = stack_top;
							next_pc_load = 1'b1;
							next_stack_pop = 1'b1;
							next_op_done = 1'b1;
							if (op_code == OP_RETURN_IMM) begin
								next_accumulator_reg = op_imm;
							end
							if (op_code == OP_IRQ_RETURN) begin
								next_master_irq_enable = 1'b1;
								// Pending request vectors before main resumes
								next_irq_take = irq_pending;
							end
						end
						OP_OR_MEM, OP_ROT_LEFT: begin
							// Read first, modify and write two cycles later
							next_held_op = op_code;
							next_mem_addr = op_addr;
							next_mem_rd = 1'b1;
							next_op_ready = 1'b0;
							next_state = ST_READ;
						end
						default: begin
							next_op_done = 1'b1;
						end
					endcase
				end
			end
			ST_READ: begin
				next_state = ST_WRITE;
			end
			ST_WRITE: begin
				next_mem_wr = 1'b1;
				if (held_op == OP_OR_MEM) begin
					next_mem_wdata = or_mem_res;
					next_zero_flag = (or_mem_res == ZERO_BYTE);
				end else begin
					next_mem_wdata = rot_res;
				end
				next_op_done = 1'b1;
				next_op_ready = 1'b1;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
				next_op_ready = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			state             <= ST_IDLE;
			held_op           <= OP_NONE;
			accumulator_reg   <= ACCUM_RESET;
			zero_flag         <= 1'b0;
			master_irq_enable <= 1'b0;
			pc_load_value     <= PC_RESET;
			pc_load           <= 1'b0;
			stack_pop         <= 1'b0;
			irq_take          <= 1'b0;
			mem_addr          <= '0;
			mem_rd            <= 1'b0;
			mem_wr            <= 1'b0;
			mem_wdata         <= ZERO_BYTE;
			op_done           <= 1'b0;
			op_ready          <= 1'b1;
		end else begin
			state             <= next_state;
			held_op           <= next_held_op;
			accumulator_reg   <= next_accumulator_reg;
			zero_flag         <= next_zero_flag;
			master_irq_enable <= next_master_irq_enable;
			pc_load_value     <= next_pc_load_value;
			pc_load           <= next_pc_load;
			stack_pop         <= next_stack_pop;
			irq_take          <= next_irq_take;
			mem_addr          <= next_mem_addr;
			mem_rd            <= next_mem_rd;
			mem_wr            <= next_mem_wr;
			mem_wdata         <= next_mem_wdata;
			op_done           <= next_op_done;
			op_ready          <= next_op_ready;
		end
	end

	// ==========================================================
	// Checks
	or_imm_a: assert property (@(posedge clk) disable iff (srst)
		op_valid && op_ready && state == ST_IDLE && op_code == OP_OR_IMM
		|=> accumulator_reg == ($past(accumulator_reg) | $past(op_imm))
		&& zero_flag == (accumulator_reg == ZERO_BYTE))
		else $error("or immediate result wrong");

	or_mem_a: assert property (@(posedge clk) disable iff (srst)
		state == ST_WRITE && held_op == OP_OR_MEM
		|=> mem_wr && mem_wdata == ($past(accumulator_reg) | $past(mem_rdata))
		&& $stable(accumulator_reg))
		else $error("or to memory result wrong");

	sub_return_a: assert property (@(posedge clk) disable iff (srst)
		op_valid && op_ready && state == ST_IDLE && op_code == OP_SUB_RETURN
		|=> pc_load && stack_pop && pc_load_value == $past(stack_top)
		&& $stable(zero_flag) && $stable(accumulator_reg))
		else $error("return did not pop counter");

	return_imm_a: assert property (@(posedge clk) disable iff (srst)
		op_valid && op_ready && state == ST_IDLE && op_code == OP_RETURN_IMM
		|=> pc_load && accumulator_reg == $past(op_imm) && $stable(zero_flag))
		else $error("return with immediate wrong");

	irq_return_a: assert property (@(posedge clk) disable iff (srst)
		op_valid && op_ready && state == ST_IDLE && op_code == OP_IRQ_RETURN
		|=> master_irq_enable && pc_load && stack_pop)
		else $error("irq return did not enable");

	pending_take_a: assert property (@(posedge clk) disable iff (srst)
		op_valid && op_ready && state == ST_IDLE && op_code == OP_IRQ_RETURN
		&& irq_pending |=> irq_take)
		else $error("pending irq not taken");

	rot_left_a: assert property (@(posedge clk) disable iff (srst)
		state == ST_WRITE && held_op == OP_ROT_LEFT
		|=> mem_wr && mem_wdata == {$past(mem_rdata[MSB-1:0]),
		$past(mem_rdata[MSB])} && $stable(zero_flag))
		else $error("rotate left result wrong");

	rmw_seq_a: assert property (@(posedge clk) disable iff (srst)
		mem_rd |=> !mem_wr ##1 mem_wr && $stable(mem_addr))
		else $error("read-modify-write order wrong");

endmodule

/* File: tb/or_return_rotate_exec_tb.sv */
// Self-checking testbench for the OR, return and rotate executor
`timescale 1ns/1ps

module or_return_rotate_exec_tb;
	import exec_pkg::*;
	// ====================
	// Stimulus and observed signals
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              op_valid = 1'b0;
	op_type            op_code = OP_NONE;
	logic [DATA_W-1:0] op_imm = 8'h00;
	logic [ADDR_W-1:0] op_addr = 8'h00;
	logic [PC_W-1:0]   stack_top = 13'h0000;
	logic              irq_pending = 1'b0;
	logic [DATA_W-1:0] mem_rdata = 8'h00;
	logic              op_ready, op_done, zero_flag, master_irq_enable;
	logic              pc_load, stack_pop, irq_take, mem_rd, mem_wr;
	logic [DATA_W-1:0] accumulator_reg, mem_wdata;
	logic [ADDR_W-1:0] mem_addr;
	logic [PC_W-1:0]   pc_load_value;
	int                error_cnt = 0;
	int                compares = 0;
	int                cycles = 0;

	or_return_rotate_exec or_return_rotate_exec_inst (
		.clk               (clk),
		.srst              (srst),
		.op_valid          (op_valid),
		.op_code           (op_code),
		.op_imm            (op_imm),
		.op_addr           (op_addr),
		.stack_top         (stack_top),
		.irq_pending       (irq_pending),
		.mem_rdata         (mem_rdata),
		.op_ready          (op_ready),
		.op_done           (op_done),
		.accumulator_reg   (accumulator_reg),
		.zero_flag         (zero_flag),
		.master_irq_enable (master_irq_enable),
		.pc_load_value     (pc_load_value),
		.pc_load           (pc_load),
		.stack_pop         (stack_pop),
		.irq_take          (irq_take),
		.mem_addr          (mem_addr),
		.mem_rd            (mem_rd),
		.mem_wr            (mem_wr),
		.mem_wdata         (mem_wdata)
	);

	always #2 clk = ~clk;

	// ====================
	// Helpers
	task automatic chk(input string name, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// Valid stays up so register ops can run back to back
	task automatic op(input op_type c, input logic [7:0] imm, addr);
		op_valid = 1'b1;
		op_code = c;
		op_imm = imm;
		op_addr = addr;
		step();
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ====================
	// Scenarios
	task automatic t_or_imm();
		op(OP_OR_IMM, 8'h00, 8'h00);
		chk("accumulator", accumulator_reg, 8'h00);
		chk("zero", zero_flag, 1'b1);
		op(OP_OR_IMM, 8'h5a, 8'h00);
		chk("accumulator", accumulator_reg, 8'h5a);
		chk("zero", zero_flag, 1'b0);
		op(OP_OR_IMM, 8'h81, 8'h00);
		chk("accumulator", accumulator_reg, 8'hdb);
		op(OP_NONE, 8'hff, 8'h00);
		chk("done", op_done, 1'b1);
		chk("accumulator", accumulator_reg, 8'hdb);
	endtask

	task automatic t_returns();
		stack_top = 13'h1abc;
		op(OP_RETURN_IMM, 8'h00, 8'h00);
		chk("accumulator", accumulator_reg, 8'h00);
		chk("zero", zero_flag, 1'b0);
		chk("pcv", pc_load_value, 13'h1abc);
		chk("pop", {pc_load, stack_pop}, 2'b11);
		stack_top = 13'h0123;
		op(OP_SUB_RETURN, 8'h77, 8'h00);
		chk("pcv", pc_load_value, 13'h0123);
		chk("flags", {accumulator_reg, zero_flag}, 9'h000);
		chk("pop", {pc_load, stack_pop, op_done}, 3'b111);
		stack_top = 13'h0042;
		op(OP_IRQ_RETURN, 8'h00, 8'h00);
		chk("mie", master_irq_enable, 1'b1);
		chk("take", irq_take, 1'b0);
		chk("pcv", pc_load_value, 13'h0042);
		irq_pending = 1'b1;
		op(OP_IRQ_RETURN, 8'h00, 8'h00);
		chk("take", irq_take, 1'b1);
		chk("zero", zero_flag, 1'b0);
		op_valid = 1'b0;
		irq_pending = 1'b0;
		step();
		chk("pulses", {irq_take, pc_load, stack_pop, op_done}, 4'h0);
	endtask

	// Read-modify-write, with a request pushed while busy
	task automatic t_mem(input op_type c, input logic [7:0] a, rd, wr,
			input logic z, input logic [7:0] acc);
		op(c, 8'h00, a);
		op_code = OP_OR_IMM;
		op_imm = 8'hff;
		chk("rd", {mem_rd, op_ready}, 2'b10);
		chk("addr", mem_addr, a);
		step();
		op_valid = 1'b0;
		mem_rdata = rd;
		step();
		mem_rdata = ~rd;
		chk("wr", {mem_wr, op_done}, 2'b11);
		chk("wdata", mem_wdata, wr);
		chk("zero", zero_flag, z);
		step();
		chk("accumulator", accumulator_reg, acc);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		srst = 1'b0;
		chk("ready", {op_ready, master_irq_enable, zero_flag}, 3'b100);
		chk("accumulator", accumulator_reg, 8'h00);
		t_or_imm();
		t_returns();
		t_mem(OP_OR_MEM, 8'h10, 8'h00, 8'h00, 1'b1, 8'h00);
		t_mem(OP_ROT_LEFT, 8'h11, 8'h81, 8'h03, 1'b1, 8'h00);
		op(OP_OR_IMM, 8'h30, 8'h00);
		op_valid = 1'b0;
		step();
		t_mem(OP_OR_MEM, 8'hfe, 8'h05, 8'h35, 1'b0, 8'h30);
		t_mem(OP_ROT_LEFT, 8'hff, 8'h40, 8'h80, 1'b0, 8'h30);
		wrap_up();
	end
endmodule
